/* File: verilog/pirc_pkg.sv */
// constants shared by the interrupt and reset-cause block
package pirc_pkg;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned GPIO_N = 15;
    localparam int unsigned ADC_N = 5;
    // register offsets
    localparam logic [7:0] OFS_L1_STATUS = 8'h02;
    localparam logic [7:0] OFS_ADC_STATUS = 8'h03;
    localparam logic [7:0] OFS_REG_STATUS = 8'h04;
    localparam logic [7:0] OFS_THERMAL_GROUP_STATUS = 8'h05;
    localparam logic [7:0] OFS_BTN_STATUS = 8'h06;
    localparam logic [7:0] OFS_GPIO_HI_STATUS = 8'h0B;
    localparam logic [7:0] OFS_GPIO_LO_STATUS = 8'h0C;
    localparam logic [7:0] OFS_L1_MASK = 8'h0E;
    localparam logic [7:0] OFS_ADC_MASK = 8'h10;
    localparam logic [7:0] OFS_REG_MASK = 8'h11;
    localparam logic [7:0] OFS_THERMAL_GROUP_MASK = 8'h12;
    localparam logic [7:0] OFS_BTN_MASK = 8'h13;
    localparam logic [7:0] OFS_GPIO_HI_MASK = 8'h19;
    localparam logic [7:0] OFS_GPIO_LO_MASK = 8'h1A;
    localparam logic [7:0] OFS_CAUSE_A = 8'h20;
    localparam logic [7:0] OFS_CAUSE_B = 8'h21;
    localparam logic [7:0] OFS_WAKE = 8'h22;
    localparam logic [7:0] OFS_EDGE_SEL0 = 8'h30;
    localparam logic [7:0] OFS_PIN_LEVEL_HI = 8'h34;
    localparam logic [7:0] OFS_PIN_LEVEL_LO = 8'h35;
    // first-level bit positions
    localparam int unsigned L1_REGULATOR_BIT = 6;
    localparam int unsigned L1_PIN_BIT = 5;
    localparam int unsigned L1_CONVERTER_BIT = 3;
    localparam int unsigned L1_THERMAL_BIT = 1;
    localparam logic [7:0] L1_VALID = 8'h6A;
    // reset values, valid-bit masks and charger field positions
    localparam logic [7:0] L1_MASK_RESET = 8'h6A;
    localparam logic [ADC_N-1:0] ADC_MASK_RESET = 5'h1F;
    localparam logic [GPIO_N-1:0] GPIO_MASK_RESET = 15'h7FFF;
    localparam logic [7:0] CAUSE_A_VALID = 8'hF7;
    localparam logic [7:0] CAUSE_B_EVENT_VALID = 8'hF0;
    localparam logic [7:0] WAKE_VALID = 8'h01;
    localparam int unsigned CHG_RES_LSB = 2;
    localparam int unsigned CHG_VOLT_LSB = 0;
    // edge select codes
    localparam logic [1:0] EDGE_NONE = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
    // timing
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned IRQ_LATENCY_NS = 1000000;
    localparam int unsigned IRQ_LATENCY_CYCLES = IRQ_LATENCY_NS / CLK_PERIOD_NS;
    localparam int unsigned IRQ_PATH_CYCLES = 3;
endpackage

/* File: verilog/pirc_status_bank.sv */
// sticky write-one-to-clear status bits with per-bit masks
module pirc_status_bank
    import pirc_pkg::*;
#(
    parameter int unsigned WIDTH = 1
) (
    input wire logic core_clk_in,
    input wire logic srst_in,
    input wire logic clear_all_in,
    input wire logic [WIDTH-1:0] event_in,
    input wire logic [WIDTH-1:0] mask_in,
    input wire logic [WIDTH-1:0] w1c_in,
    output logic [WIDTH-1:0] status_out
);
    initial begin
        if (WIDTH < 1 || WIDTH > DATA_W * 2) begin
            $error("status bank width out of range");
        end
    end

    logic [WIDTH-1:0] status_q;

    // set wins over both the host clear and the cold-off clear
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            status_q <= '0;
        end else begin
            status_q <= (status_q & ~w1c_in & ~{WIDTH{clear_all_in}})
                        | (event_in & ~mask_in);
        end
    end

    assign status_out = status_q;
endmodule

/* File: verilog/pirc_edge_detect.sv */
// per-pin programmable edge detection with level readback
module pirc_edge_detect
    import pirc_pkg::*;
#(
    parameter int unsigned PINS = GPIO_N
) (
    input wire logic core_clk_in,
    input wire logic srst_in,
    input wire logic [PINS-1:0] pin_in,
    input wire logic [2*PINS-1:0] edge_sel_in,
    output logic [PINS-1:0] event_out,
    output logic [PINS-1:0] level_out
);
    initial begin
        if (PINS < 1 || PINS > DATA_W * 2) begin
            $error("pin count out of range");
        end
    end

    logic [PINS-1:0] prev_q;
    logic primed_q;

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            prev_q <= '0;
            primed_q <= 1'b0;
        end else begin
            prev_q <= pin_in;
            primed_q <= 1'b1;
        end
    end

    always_comb begin
        for (int i = 0; i < PINS; i++) begin
            unique case (edge_sel_in[2*i +: 2])
                EDGE_RISE: event_out[i] = primed_q & pin_in[i] & ~prev_q[i];
                EDGE_FALL: event_out[i] = primed_q & ~pin_in[i] & prev_q[i];
                EDGE_BOTH: event_out[i] = primed_q & (pin_in[i] ^ prev_q[i]);
                EDGE_NONE: event_out[i] = 1'b0;
            endcase
        end
    end

    assign level_out = prev_q;
endmodule

/* File: verilog/pirc_top.sv */
// two-level interrupt tree, reset-cause and wake-cause registers
// How it works
// - cause registers reset only by backup domain
// - write one clears a cause bit
// - new cause wipes stale bits in both
// - cause_a bits 7..5 record converter overtemp
// - cause_a bits 4,2,1,0 software, button, die, trip
// - cause_b bits 7..4 supply, overvoltage, normal off
// - cause_b bits 3:2 charger resistor select
// - cause_b bits 1:0 charger voltage select
// - wake bit0 button, cleared, stale wiped
// - irq high while unmasked first-level bit set
// - irq asserts well within one millisecond
// - irq drops once unmasked bits cleared
// - first-level mask blocks status and irq
// - first-level status clears only implicitly
// - first-level bits 6,5,3,1 groups
// - first-level mask same bits, reset 0x6A
// - masked second-level bits never set
// - second-level and button bits write-one-clear
// - regulator fault cleared on cold off
// - second-level sources routed to groups
// - pin edge select, level readable
module pirc_top
    import pirc_pkg::*;
#(
    parameter int unsigned IRQ_LATENCY_LIMIT = IRQ_LATENCY_CYCLES
) (
    input wire logic core_clk_in,
    input wire logic srst_in,
    input wire logic backup_srst_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    input wire logic [ADC_N-1:0] converter_event_in,
    input wire logic regulator_fault_event_in,
    input wire logic die_temp_alert_in,
    input wire logic button_event_in,
    input wire logic [GPIO_N-1:0] gpio_pin_in,
    input wire logic cold_off_in,
    input wire logic [7:0] cause_a_event_in,
    input wire logic [3:0] cause_b_event_in,
    input wire logic wake_by_button_in,
    output logic irq_out,
    output logic [1:0] coin_charger_resistor_sel_out,
    output logic [1:0] coin_charger_voltage_sel_out
);
    initial begin
        if (IRQ_LATENCY_LIMIT < IRQ_PATH_CYCLES) begin
            $error("irq path slower than allowed latency");
        end
    end

    function automatic logic [7:0] w1c_for(input logic [7:0] ofs, input logic wr,
                                            input logic [7:0] addr, input logic [7:0] data);
        w1c_for = (wr && addr == ofs) ? data : 8'h00;
    endfunction

    function automatic logic hit(input logic [7:0] ofs, input logic wr,
                                 input logic [7:0] addr);
        hit = wr && addr == ofs;
    endfunction

    logic [7:0] l1_mask_q;
    logic [7:0] l1_status_q;
    logic [ADC_N-1:0] adc_mask_q;
    logic reg_mask_q;
    logic thermal_group_mask_q;
    logic btn_mask_q;
    logic [GPIO_N-1:0] gpio_mask_q;
    logic [2*GPIO_N-1:0] edge_sel_q;
    logic [7:0] cause_a_q;
    logic [7:0] cause_b_q;
    logic [7:0] wake_q;
    logic irq_q;
    logic [7:0] rdata_q;

    logic [ADC_N-1:0] adc_status;
    logic reg_status;
    logic thermal_group_status;
    logic btn_status;
    logic [GPIO_N-1:0] gpio_status;
    logic [GPIO_N-1:0] gpio_event;
    logic [GPIO_N-1:0] gpio_level;
    logic [7:0] gpio_w1c_hi;
    logic [7:0] gpio_w1c_lo;
    logic [7:0] adc_w1c;
    logic [7:0] reg_w1c;
    logic [7:0] thermal_group_w1c;
    logic [7:0] btn_w1c;
    logic [7:0] l1_d;
    logic new_cause;

    assign adc_w1c = w1c_for(OFS_ADC_STATUS, reg_wr_in, reg_addr_in, reg_wdata_in);
    assign reg_w1c = w1c_for(OFS_REG_STATUS, reg_wr_in, reg_addr_in, reg_wdata_in);
    assign thermal_group_w1c = w1c_for(OFS_THERMAL_GROUP_STATUS, reg_wr_in, reg_addr_in, reg_wdata_in);
    assign btn_w1c = w1c_for(OFS_BTN_STATUS, reg_wr_in, reg_addr_in, reg_wdata_in);
    assign gpio_w1c_hi = w1c_for(OFS_GPIO_HI_STATUS, reg_wr_in, reg_addr_in, reg_wdata_in);
    assign gpio_w1c_lo = w1c_for(OFS_GPIO_LO_STATUS, reg_wr_in, reg_addr_in, reg_wdata_in);

    // converter group: supply range, three voltage alerts, conversion done
    pirc_status_bank #(
        .WIDTH(ADC_N)
    ) u_adc_bank (
        .core_clk_in(core_clk_in),
        .srst_in(srst_in),
        .clear_all_in(1'b0),
        .event_in(converter_event_in),
        .mask_in(adc_mask_q),
        .w1c_in(adc_w1c[ADC_N-1:0]),
        .status_out(adc_status)
    );

    pirc_status_bank #(
        .WIDTH(1)
    ) u_reg_bank (
        .core_clk_in(core_clk_in),
        .srst_in(srst_in),
        .clear_all_in(cold_off_in),
        .event_in(regulator_fault_event_in),
        .mask_in(reg_mask_q),
        .w1c_in(reg_w1c[0]),
        .status_out(reg_status)
    );

    pirc_status_bank #(
        .WIDTH(1)
    ) u_thermal_group_bank (
        .core_clk_in(core_clk_in),
        .srst_in(srst_in),
        .clear_all_in(1'b0),
        .event_in(die_temp_alert_in),
        .mask_in(thermal_group_mask_q),
        .w1c_in(thermal_group_w1c[0]),
        .status_out(thermal_group_status)
    );

    pirc_status_bank #(
        .WIDTH(1)
    ) u_btn_bank (
        .core_clk_in(core_clk_in),
        .srst_in(srst_in),
        .clear_all_in(1'b0),
        .event_in(button_event_in),
        .mask_in(btn_mask_q),
        .w1c_in(btn_w1c[0]),
        .status_out(btn_status)
    );

    pirc_edge_detect #(
        .PINS(GPIO_N)
    ) u_edges (
        .core_clk_in(core_clk_in),
        .srst_in(srst_in),
        .pin_in(gpio_pin_in),
        .edge_sel_in(edge_sel_q),
        .event_out(gpio_event),
        .level_out(gpio_level)
    );

    pirc_status_bank #(
        .WIDTH(GPIO_N)
    ) u_gpio_bank (
        .core_clk_in(core_clk_in),
        .srst_in(srst_in),
        .clear_all_in(1'b0),
        .event_in(gpio_event),
        .mask_in(gpio_mask_q),
        .w1c_in({gpio_w1c_hi[6:0], gpio_w1c_lo}),
        .status_out(gpio_status)
    );

    // mask registers
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            l1_mask_q <= L1_MASK_RESET;
            adc_mask_q <= ADC_MASK_RESET;
            reg_mask_q <= 1'b1;
            thermal_group_mask_q <= 1'b1;
            btn_mask_q <= 1'b1;
            gpio_mask_q <= GPIO_MASK_RESET;
        end else begin
            if (hit(OFS_L1_MASK, reg_wr_in, reg_addr_in)) begin
                l1_mask_q <= reg_wdata_in & L1_VALID;
            end
            if (hit(OFS_ADC_MASK, reg_wr_in, reg_addr_in)) begin
                adc_mask_q <= reg_wdata_in[ADC_N-1:0];
            end
            if (hit(OFS_REG_MASK, reg_wr_in, reg_addr_in)) begin
                reg_mask_q <= reg_wdata_in[0];
            end
            if (hit(OFS_THERMAL_GROUP_MASK, reg_wr_in, reg_addr_in)) begin
                thermal_group_mask_q <= reg_wdata_in[0];
            end
            if (hit(OFS_BTN_MASK, reg_wr_in, reg_addr_in)) begin
                btn_mask_q <= reg_wdata_in[0];
            end
            if (hit(OFS_GPIO_HI_MASK, reg_wr_in, reg_addr_in)) begin
                gpio_mask_q[14:8] <= reg_wdata_in[6:0];
            end
            if (hit(OFS_GPIO_LO_MASK, reg_wr_in, reg_addr_in)) begin
                gpio_mask_q[7:0] <= reg_wdata_in;
            end
        end
    end

    // edge select: four pins per register
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            edge_sel_q <= '0;
        end else begin
            for (int k = 0; k < 4; k++) begin
                if (hit(OFS_EDGE_SEL0 + 8'(k), reg_wr_in, reg_addr_in)) begin
                    for (int j = 0; j < 4; j++) begin
                        if (4 * k + j < GPIO_N) begin
                            edge_sel_q[2*(4*k+j) +: 2] <= reg_wdata_in[2*j +: 2];
                        end
                    end
                end
            end
        end
    end

    // first-level status is derived from unmasked second-level bits only
    always_comb begin
        l1_d = 8'h00;
        l1_d[L1_REGULATOR_BIT] = reg_status & ~reg_mask_q;
        l1_d[L1_PIN_BIT] = |(gpio_status & ~gpio_mask_q);
        l1_d[L1_CONVERTER_BIT] = |(adc_status & ~adc_mask_q);
        l1_d[L1_THERMAL_BIT] = thermal_group_status & ~thermal_group_mask_q;
        l1_d = l1_d & ~l1_mask_q & L1_VALID;
    end

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            l1_status_q <= 8'h00;
        end else begin
            l1_status_q <= l1_d;
        end
    end

    // irq follows unmasked first-level bits and the button bit
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(l1_status_q & ~l1_mask_q) | (btn_status & ~btn_mask_q);
        end
    end

    // cause registers live in the backup domain
    assign new_cause = |(cause_a_event_in & CAUSE_A_VALID) | (|cause_b_event_in);

    always_ff @(posedge core_clk_in) begin
        if (backup_srst_in) begin
            cause_a_q <= 8'h00;
            cause_b_q <= 8'h00;
        end else begin
            if (new_cause) begin
                cause_a_q <= cause_a_event_in & CAUSE_A_VALID;
                cause_b_q[7:4] <= cause_b_event_in;
            end else begin
                cause_a_q <= cause_a_q
                    & ~w1c_for(OFS_CAUSE_A, reg_wr_in, reg_addr_in, reg_wdata_in);
                cause_b_q[7:4] <= cause_b_q[7:4]
                    & ~reg_wdata_in[7:4] | {4{~hit(OFS_CAUSE_B, reg_wr_in, reg_addr_in)}}
                    & cause_b_q[7:4];
            end
            if (hit(OFS_CAUSE_B, reg_wr_in, reg_addr_in)) begin
                cause_b_q[3:0] <= reg_wdata_in[3:0];
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (backup_srst_in) begin
            wake_q <= 8'h00;
        end else if (wake_by_button_in) begin
            wake_q <= WAKE_VALID;
        end else begin
            wake_q <= wake_q & WAKE_VALID
                & ~w1c_for(OFS_WAKE, reg_wr_in, reg_addr_in, reg_wdata_in);
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (backup_srst_in) begin
            coin_charger_resistor_sel_out <= 2'h0;
            coin_charger_voltage_sel_out <= 2'h0;
        end else if (hit(OFS_CAUSE_B, reg_wr_in, reg_addr_in)) begin
            coin_charger_resistor_sel_out <= reg_wdata_in[CHG_RES_LSB +: 2];
            coin_charger_voltage_sel_out <= reg_wdata_in[CHG_VOLT_LSB +: 2];
        end
    end

    // read port, data valid the cycle after the read strobe
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            rdata_q <= 8'h00;
        end else if (reg_rd_in) begin
            unique case (reg_addr_in)
                OFS_L1_STATUS: rdata_q <= l1_status_q;
                OFS_L1_MASK: rdata_q <= l1_mask_q;
                OFS_ADC_STATUS: rdata_q <= {3'h0, adc_status};
                OFS_ADC_MASK: rdata_q <= {3'h0, adc_mask_q};
                OFS_REG_STATUS: rdata_q <= {7'h00, reg_status};
                OFS_REG_MASK: rdata_q <= {7'h00, reg_mask_q};
                OFS_THERMAL_GROUP_STATUS: rdata_q <= {7'h00, thermal_group_status};
                OFS_THERMAL_GROUP_MASK: rdata_q <= {7'h00, thermal_group_mask_q};
                OFS_BTN_STATUS: rdata_q <= {7'h00, btn_status};
                OFS_BTN_MASK: rdata_q <= {7'h00, btn_mask_q};
                OFS_GPIO_HI_STATUS: rdata_q <= {1'b0, gpio_status[14:8]};
                OFS_GPIO_LO_STATUS: rdata_q <= gpio_status[7:0];
                OFS_GPIO_HI_MASK: rdata_q <= {1'b0, gpio_mask_q[14:8]};
                OFS_GPIO_LO_MASK: rdata_q <= gpio_mask_q[7:0];
                OFS_CAUSE_A: rdata_q <= cause_a_q;
                OFS_CAUSE_B: rdata_q <= cause_b_q;
                OFS_WAKE: rdata_q <= wake_q;
                OFS_EDGE_SEL0: rdata_q <= edge_sel_q[7:0];
                OFS_EDGE_SEL0 + 8'h01: rdata_q <= edge_sel_q[15:8];
                OFS_EDGE_SEL0 + 8'h02: rdata_q <= edge_sel_q[23:16];
                OFS_EDGE_SEL0 + 8'h03: rdata_q <= {2'h0, edge_sel_q[29:24]};
                OFS_PIN_LEVEL_HI: rdata_q <= {1'b0, gpio_level[14:8]};
                OFS_PIN_LEVEL_LO: rdata_q <= gpio_level[7:0];
                default: rdata_q <= 8'h00;
            endcase
        end
    end

    assign reg_rdata_out = rdata_q;
    assign irq_out = irq_q;
endmodule

/* File: testbench/pirc_checker.sv */
// port assertions for the interrupt block
module pirc_checker
    import pirc_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic srst_in,
    input wire logic backup_srst_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic die_temp_alert_in,
    input wire logic irq_out,
    input wire logic [1:0] coin_charger_resistor_sel_out,
    input wire logic [1:0] coin_charger_voltage_sel_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] l1_m_q;
    logic thermal_group_m_q, btn_m_q, all_m, chg_wr;
    logic [3:0] chg_sel, wdata_lo;
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            {l1_m_q, thermal_group_m_q, btn_m_q} <= {L1_MASK_RESET, 2'h3};
        end else if (reg_wr_in) begin
            l1_m_q <= (reg_addr_in == OFS_L1_MASK) ? reg_wdata_in & L1_VALID : l1_m_q;
            thermal_group_m_q <= (reg_addr_in == OFS_THERMAL_GROUP_MASK) ? reg_wdata_in[0] : thermal_group_m_q;
            btn_m_q <= (reg_addr_in == OFS_BTN_MASK) ? reg_wdata_in[0] : btn_m_q;
        end
    end
    assign all_m = (l1_m_q == L1_VALID) && btn_m_q;
    assign chg_wr = reg_wr_in && reg_addr_in == OFS_CAUSE_B;
    assign chg_sel = {coin_charger_resistor_sel_out, coin_charger_voltage_sel_out};
    assign wdata_lo = reg_wdata_in[3:0];
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (srst_in);
    a_irq_after_reset: assert property ($fell(srst_in) |-> !irq_out)
        else $error("irq after reset");
    a_alert_to_irq: assert property (
        die_temp_alert_in && !thermal_group_m_q && !l1_m_q[L1_THERMAL_BIT] |-> ##3 irq_out)
        else $error("alert missed");
    a_masked_irq_low: assert property (all_m [*3] |-> !irq_out)
        else $error("irq while masked");
    a_chg_follows_write: assert property (
        chg_wr && !backup_srst_in |=> chg_sel == $past(wdata_lo))
        else $error("charger write lost");
    a_chg_holds: assert property (!chg_wr && !backup_srst_in |=> $stable(chg_sel))
        else $error("charger drifted");
    a_rdata_holds: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
        else $error("rdata drifted");
    a_unmapped_zero: assert property (
        reg_rd_in && reg_addr_in >= 8'h40 |=> reg_rdata_out == 8'h00)
        else $error("unmapped nonzero");
    a_l1_reserved_zero: assert property (
        reg_rd_in && reg_addr_in == OFS_L1_STATUS |=> (reg_rdata_out & 8'h95) == 8'h00)
        else $error("l1 reserved set");
    a_mask_readback: assert property (
        reg_rd_in && reg_addr_in == OFS_L1_MASK |=> reg_rdata_out == l1_m_q)
        else $error("l1 mask wrong");
    a_wake_reserved: assert property (
        reg_rd_in && reg_addr_in == OFS_WAKE |=> reg_rdata_out[7:1] == 7'h00)
        else $error("wake reserved set");
    c_irq_rise: cover property ($rose(irq_out));
    c_alert_taken: cover property (die_temp_alert_in && !thermal_group_m_q && !l1_m_q[L1_THERMAL_BIT]);
    c_chg_write: cover property (chg_wr);
endmodule

bind pirc_top pirc_checker u_pirc_checker (
    .core_clk_in(core_clk_in), .srst_in(srst_in), .backup_srst_in(backup_srst_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .die_temp_alert_in(die_temp_alert_in), .irq_out(irq_out),
    .coin_charger_resistor_sel_out(coin_charger_resistor_sel_out),
    .coin_charger_voltage_sel_out(coin_charger_voltage_sel_out)
);

/* File: testbench/pirc_host_model.sv */
// host register master
module pirc_host_model (
    input wire logic core_clk_in,
    input wire logic [7:0] reg_rdata_in,
    output logic [7:0] reg_addr_out,
    output logic [7:0] reg_wdata_out,
    output logic reg_wr_out,
    output logic reg_rd_out
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {reg_addr_out, reg_wdata_out, reg_wr_out, reg_rd_out} = {8'hA5, 8'h5A, 2'h0};
    // idle bus shows inverted values
    task automatic wr(input logic [7:0] a, v);
        @(posedge core_clk_in);
        reg_addr_out <= a;
        reg_wdata_out <= v;
        reg_wr_out <= 1'b1;
        @(posedge core_clk_in);
        reg_wr_out <= 1'b0;
        reg_addr_out <= ~a;
        reg_wdata_out <= ~v;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge core_clk_in);
        reg_addr_out <= a;
        reg_rd_out <= 1'b1;
        @(posedge core_clk_in);
        reg_rd_out <= 1'b0;
        reg_addr_out <= ~a;
        @(posedge core_clk_in);
        v = reg_rdata_in;
    endtask
endmodule

/* File: testbench/tb_pirc_top.sv */
// self-checking bench for the interrupt block
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin error_cnt++; \
    $display("ERROR %0t: got %h want %h", $time, (got), (exp)); end end
module tb_pirc_top
    import pirc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk_in, srst_in, backup_srst_in, reg_wr_in, reg_rd_in, irq_out, wake_by_button_in;
    logic regulator_fault_event_in, die_temp_alert_in, button_event_in, cold_off_in;
    logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, cause_a_event_in, d, v;
    logic [ADC_N-1:0] converter_event_in;
    logic [GPIO_N-1:0] gpio_pin_in;
    logic [3:0] cause_b_event_in;
    logic [1:0] coin_charger_resistor_sel_out, coin_charger_voltage_sel_out;
    int error_cnt = 0, check_count = 0, cyc = 0;
    logic [7:0] mo_tab [4] = '{OFS_ADC_MASK, OFS_REG_MASK, OFS_THERMAL_GROUP_MASK, OFS_GPIO_LO_MASK};
    logic [7:0] so_tab [4] = '{OFS_ADC_STATUS, OFS_REG_STATUS, OFS_THERMAL_GROUP_STATUS,
        OFS_GPIO_LO_STATUS};
    int l1_tab [4] = '{L1_CONVERTER_BIT, L1_REGULATOR_BIT, L1_THERMAL_BIT, L1_PIN_BIT};
    logic [7:0] ro [6] = '{OFS_L1_STATUS, OFS_L1_MASK, OFS_CAUSE_A, OFS_CAUSE_B, OFS_WAKE, 8'h7F};
    logic [7:0] rv [6] = '{8'h00, 8'h6A, 8'h00, 8'h00, 8'h00, 8'h00};

    pirc_host_model host (
        .core_clk_in(core_clk_in), .reg_rdata_in(reg_rdata_out), .reg_addr_out(reg_addr_in),
        .reg_wdata_out(reg_wdata_in), .reg_wr_out(reg_wr_in), .reg_rd_out(reg_rd_in)
    );
    pirc_top dut (
        .core_clk_in(core_clk_in), .srst_in(srst_in), .backup_srst_in(backup_srst_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
        .converter_event_in(converter_event_in),
        .regulator_fault_event_in(regulator_fault_event_in),
        .die_temp_alert_in(die_temp_alert_in), .button_event_in(button_event_in),
        .gpio_pin_in(gpio_pin_in), .cold_off_in(cold_off_in),
        .cause_a_event_in(cause_a_event_in), .cause_b_event_in(cause_b_event_in),
        .wake_by_button_in(wake_by_button_in), .irq_out(irq_out),
        .coin_charger_resistor_sel_out(coin_charger_resistor_sel_out),
        .coin_charger_voltage_sel_out(coin_charger_voltage_sel_out)
    );

    initial begin
        core_clk_in = 1'b0;
        forever #50 core_clk_in = ~core_clk_in;
    end

    always @(posedge core_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            error_cnt++;
            $display("ERROR %0t: timeout", $time);
            end_of_test();
        end
    end

    task automatic end_of_test();
        if (error_cnt == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic quiet();
        {regulator_fault_event_in, die_temp_alert_in, button_event_in, cold_off_in} <= 4'h0;
        {wake_by_button_in, converter_event_in, gpio_pin_in} <= '0;
        {cause_a_event_in, cause_b_event_in} <= 12'h000;
    endtask

    task automatic pulse(input int g, input int b);
        @(posedge core_clk_in);
        case (g)
            0: converter_event_in <= 5'h01 << b;
            1: regulator_fault_event_in <= 1'b1;
            2: die_temp_alert_in <= 1'b1;
            3: gpio_pin_in[b] <= 1'b1;
            4: button_event_in <= 1'b1;
            5: cold_off_in <= 1'b1;
            6: wake_by_button_in <= 1'b1;
            7: cause_b_event_in <= 4'(b);
            default: cause_a_event_in <= 8'(b);
        endcase
        @(posedge core_clk_in);
        quiet();
    endtask

    task automatic run_group(input int g);
        int b;
        logic [7:0] mo, so, bm;
        b = (g == 0) ? $urandom_range(4) : (g == 3) ? $urandom_range(14) : 0;
        mo = (g == 3 && b > 7) ? OFS_GPIO_HI_MASK : mo_tab[g];
        so = (g == 3 && b > 7) ? OFS_GPIO_HI_STATUS : so_tab[g];
        bm = 8'h01 << (b % 8);
        if (g == 3) begin
            host.wr(OFS_EDGE_SEL0 + 8'(b / 4), 8'({6'h00, EDGE_RISE} << (2 * (b % 4))));
        end
        pulse(g, b);
        host.rd(so, d);
        `CHK(d & bm, 8'h00)
        host.wr(mo, ~bm);
        pulse(g, b);
        host.rd(so, d);
        `CHK(d & bm, bm)
        host.rd(OFS_L1_STATUS, d);
        `CHK(d, 8'h00)
        `CHK(irq_out, 1'b0)
        host.wr(OFS_L1_MASK, L1_VALID ^ (8'h01 << l1_tab[g]));
        host.wr(OFS_L1_STATUS, 8'hFF);
        host.rd(OFS_L1_STATUS, d);
        `CHK(d, 8'h01 << l1_tab[g])
        `CHK(irq_out, 1'b1)
        host.wr(so, bm);
        repeat (3) @(posedge core_clk_in);
        `CHK(irq_out, 1'b0)
        host.rd(so, d);
        `CHK(d & bm, 8'h00)
        pulse(g, b);
        repeat (3) @(posedge core_clk_in);
        `CHK(irq_out, 1'b1)
        if (g == 1) begin
            pulse(5, 0);
        end else begin
            host.wr(so, bm);
        end
        repeat (3) @(posedge core_clk_in);
        `CHK(irq_out, 1'b0)
        host.wr(OFS_L1_MASK, L1_VALID);
        host.wr(mo, 8'hFF);
    endtask

    initial begin
        {srst_in, backup_srst_in} = 2'b11;
        quiet();
        void'($urandom(32'h5965));
        repeat (5) @(posedge core_clk_in);
        srst_in <= 1'b0;
        backup_srst_in <= 1'b0;
        foreach (ro[i]) begin
            host.rd(ro[i], d);
            `CHK(d, rv[i])
        end
        host.wr(OFS_L1_MASK, 8'hFF);
        host.rd(OFS_L1_MASK, d);
        `CHK(d, 8'h6A)
        gpio_pin_in <= 15'($urandom);
        repeat (2) @(posedge core_clk_in);
        host.rd(OFS_PIN_LEVEL_LO, d);
        `CHK(d, gpio_pin_in[7:0])
        host.rd(OFS_PIN_LEVEL_HI, d);
        `CHK(d, {1'b0, gpio_pin_in[14:8]})
        gpio_pin_in <= 15'h0000;
        for (int g = 0; g < 4; g++) begin
            run_group(g);
        end
        host.wr(OFS_BTN_MASK, 8'h00);
        pulse(4, 0);
        repeat (3) @(posedge core_clk_in);
        `CHK(irq_out, 1'b1)
        host.wr(OFS_BTN_STATUS, 8'h01);
        repeat (3) @(posedge core_clk_in);
        `CHK(irq_out, 1'b0)
        host.wr(OFS_BTN_MASK, 8'h01);
        for (int k = 0; k < 9; k++) begin
            v = (k < 8) ? 8'h01 << k : 8'($urandom) | 8'h01;
            if (k != 3) begin
                pulse(8, v);
                host.rd(OFS_CAUSE_A, d);
                `CHK(d, v & 8'hF7)
            end
        end
        v = 8'($urandom_range(15, 1));
        pulse(7, v);
        host.rd(OFS_CAUSE_A, d);
        `CHK(d, 8'h00)
        srst_in <= 1'b1;
        repeat (5) @(posedge core_clk_in);
        srst_in <= 1'b0;
        host.rd(OFS_CAUSE_B, d);
        `CHK(d, {v[3:0], 4'h0})
        host.wr(OFS_CAUSE_B, 8'h0F & v);
        host.rd(OFS_CAUSE_B, d);
        `CHK(d, {v[3:0], v[3:0]})
        host.wr(OFS_CAUSE_B, 8'hF0);
        host.rd(OFS_CAUSE_B, d);
        `CHK(d, 8'h00)
        for (int k = 0; k < 16; k++) begin
            host.wr(OFS_CAUSE_B, 8'(k));
            host.rd(OFS_CAUSE_B, d);
            `CHK({coin_charger_resistor_sel_out, coin_charger_voltage_sel_out}, 4'(k))
        end
        pulse(6, 0);
        host.rd(OFS_WAKE, d);
        `CHK(d, 8'h01)
        host.wr(OFS_WAKE, 8'hFF);
        host.rd(OFS_WAKE, d);
        `CHK(d, 8'h00)
        end_of_test();
    end
endmodule
